// *** rtl/dtk_defines.svh ***
// Register addresses, field positions, reset values and duty figures for the test/key bank
`ifndef DTK_DEFINES_SVH
`define DTK_DEFINES_SVH
`define DTK_ADDR_DISPLAY_TEST 8'h07
`define DTK_ADDR_KEY_DEBOUNCED 8'h08
`define DTK_ADDR_KEY_PRESSED 8'h0C
`define DTK_TEST_BIT 0
`define DTK_TEST_RESET 1'h0
`define DTK_KEYS_RESET 8'h00
`define DTK_TEST_DUTY 6'h1C
`define DTK_DUTY_STEPS 6'h3F
`define DTK_DIGITS 8
`endif

// *** rtl/dtk_pkg.sv ***
// Types shared by the display test and key status bank
package dtk_pkg;
  typedef logic [7:0] dtk_byte_t;
  typedef enum logic {DTK_NORMAL, DTK_TEST} dtk_mode_e;
endpackage : dtk_pkg

// *** rtl/dtk_key_tracker.sv ***
// Key debounce event tracker: latest scan snapshot and sticky debounced flags
`timescale 1ns/10ps
`default_nettype none
`include "dtk_defines.svh"
module dtk_key_tracker
  import dtk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Scan results
  input wire logic scan_done_i,
  input wire logic [7:0] scan_hits_i,
  // Read clear
  input wire logic clear_i,
  // Status
  output logic [7:0] pressed_o,
  output logic [7:0] debounced_o,
  output logic irq_o
);
  typedef struct packed {
    dtk_byte_t pressed;
    dtk_byte_t debounced;
    dtk_byte_t armed;
    logic irq;
  } dtk_trk_s;
  dtk_trk_s state_reg;
  dtk_trk_s state_next;
  dtk_byte_t fresh;

  always_comb begin
    state_next = state_reg;
    fresh = 8'h00;
    if (clear_i) begin
      state_next.debounced = `DTK_KEYS_RESET; // RULE9
      state_next.irq = 1'b0; // RULE9
    end
    if (scan_done_i) begin
      state_next.pressed = scan_hits_i; // RULE11
      // Only keys seen released since last report may fire again
      fresh = scan_hits_i & state_reg.armed; // RULE10
      state_next.armed = ~scan_hits_i; // RULE10
      // Set wins over a same-cycle read clear
      state_next.debounced = state_next.debounced | fresh; // RULE9
      if (fresh != 8'h00) begin
        state_next.irq = 1'b1; // RULE10
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= '{pressed: `DTK_KEYS_RESET, debounced: `DTK_KEYS_RESET,
                     armed: 8'hFF, irq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pressed_o = state_reg.pressed;
  assign debounced_o = state_reg.debounced;
  assign irq_o = state_reg.irq;
endmodule : dtk_key_tracker
`default_nettype wire

// *** rtl/dtk_display_test_key_status.sv ***
// Display test override and key status register bank
// What this block does
// (RULE1) Two display states exist, and display test lights every driven LED output.
// (RULE2) Display test overrides all control and digit registers except the port setup, shutdown too, without altering them.
// (RULE3) The port setup stays in force during display test.
// (RULE4) Display test drives a fixed 28/64 duty whatever the intensity setting.
// (RULE5) Bit 0 of register 0x07 selects normal or display test; other bits are ignored.
// (RULE6) Key debounced register 0x08 holds key n in bit n.
// (RULE7) Key pressed register 0x0C holds key n in bit n.
// (RULE8) A bicolor digit is handled as two independent single-colour digits.
// (RULE9) Reading 0x08 clears it and the interrupt after returning data; unread bits accumulate.
// (RULE10) A held key is reported once and must be seen released before reporting again.
// (RULE11) 0x0C shows only the latest scan; reading clears nothing and writes are ignored.
// (RULE12) Writes to 0x08 are ignored.
// (RULE13) Display test resets to zero, normal operation.
// (RULE14) Reading 0x07 returns D0 with upper bits zero.
`timescale 1ns/10ps
`default_nettype none
`include "dtk_defines.svh"
module dtk_display_test_key_status
  import dtk_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register access from the serial decoder
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Keyscan results
  input wire logic scan_done_i,
  input wire logic [7:0] scan_hits_i,
  // Normal display settings, per digit (bicolor halves are separate digits)
  input wire logic [`DTK_DIGITS-1:0][7:0] digit_segs_i,
  input wire logic [5:0] intensity_i,
  input wire logic shutdown_i,
  input wire logic [7:0] port_cfg_i,
  // Effective display drive
  output logic [`DTK_DIGITS-1:0][7:0] drive_segs_o,
  output logic [5:0] drive_duty_o,
  output logic drive_enable_o,
  output logic [7:0] port_cfg_o,
  output logic test_active_o,
  // Interrupt request from debounced keys
  output logic key_irq_o
);
  typedef struct packed {
    dtk_mode_e mode;
    dtk_byte_t rdata;
  } dtk_bank_s;
  dtk_bank_s state_reg;
  dtk_bank_s state_next;
  logic [7:0] pressed;
  logic [7:0] debounced;
  logic clr_debounced;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] code);
    hit = (a == code);
  endfunction : hit

  // Clear takes effect on the same edge that captures the data, so the read returns the pre-clear value
  assign clr_debounced = reg_rd_i && hit(reg_addr_i, `DTK_ADDR_KEY_DEBOUNCED); // RULE9

  dtk_key_tracker u_keys (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .scan_done_i(scan_done_i),
    .scan_hits_i(scan_hits_i),
    .clear_i(clr_debounced),
    .pressed_o(pressed),
    .debounced_o(debounced),
    .irq_o(key_irq_o)
  );

  always_comb begin
    state_next = state_reg;
    // Writes to key registers fall through untouched, RULE12: only 0x07 decodes a write
    if (reg_wr_i && hit(reg_addr_i, `DTK_ADDR_DISPLAY_TEST)) begin
      state_next.mode = reg_wdata_i[`DTK_TEST_BIT] ? DTK_TEST : DTK_NORMAL; // RULE5
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `DTK_ADDR_DISPLAY_TEST: begin
          state_next.rdata = {7'h00, (state_reg.mode == DTK_TEST)}; // RULE14
        end
        `DTK_ADDR_KEY_DEBOUNCED: begin
          state_next.rdata = debounced; // RULE6
        end
        `DTK_ADDR_KEY_PRESSED: begin
          state_next.rdata = pressed; // RULE7
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= '{mode: DTK_NORMAL, rdata: 8'h00}; // RULE13
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    if (state_reg.mode == DTK_TEST) begin
      drive_segs_o = '1; // RULE1 RULE8
      drive_duty_o = `DTK_TEST_DUTY; // RULE4
      drive_enable_o = 1'b1; // RULE2
    end else begin
      drive_segs_o = digit_segs_i; // RULE2 RULE8
      drive_duty_o = intensity_i;
      drive_enable_o = !shutdown_i;
    end
  end

  assign port_cfg_o = port_cfg_i; // RULE3
  assign test_active_o = (state_reg.mode == DTK_TEST);
  assign reg_rdata_o = state_reg.rdata;
endmodule : dtk_display_test_key_status
`default_nettype wire

// *** test/dtk_sva.sv ***
// Port assertions for the display test and key bank
`timescale 1ns/10ps
`default_nettype none
module dtk_sva (
  // Watched ports
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic scan_done_i,
  input wire logic [7:0] scan_hits_i,
  input wire logic [7:0][7:0] drive_segs_o,
  input wire logic [5:0] drive_duty_o,
  input wire logic drive_enable_o,
  input wire logic test_active_o,
  input wire logic key_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence s_rd(a); reg_rd_i && !reg_wr_i && reg_addr_i == a; endsequence
  sequence s_wr7; reg_wr_i && reg_addr_i == 8'h07; endsequence
  AST_DUTY: assert property (test_active_o |-> drive_duty_o == 6'h1C) else $error("duty");
  AST_ON: assert property (test_active_o |-> drive_enable_o && &drive_segs_o)
    else $error("not all on");
  AST_MODE_WR: assert property (s_wr7 |=> test_active_o == $past(reg_wdata_i[0]))
    else $error("mode write");
  AST_MODE_KEEP: assert property (!(reg_wr_i && reg_addr_i == 8'h07) |=>
    $stable(test_active_o)) else $error("mode changed");
  AST_MODE_RD: assert property (s_rd(8'h07) |=>
    reg_rdata_o == {7'h00, $past(test_active_o)}) else $error("mode read");
  AST_DEB_CLR: assert property (s_rd(8'h08) ##0 !scan_done_i |=> !key_irq_o)
    else $error("irq kept");
  AST_IRQ_HOLD: assert property (key_irq_o && !(reg_rd_i && reg_addr_i == 8'h08)
    |=> key_irq_o) else $error("irq dropped");
  AST_IRQ_CAUSE: assert property (!key_irq_o && !(scan_done_i && |scan_hits_i)
    |=> !key_irq_o) else $error("irq no cause");
endmodule : dtk_sva
bind dtk_display_test_key_status dtk_sva dtk_sva_inst (.*);
`default_nettype wire

// *** test/dtk_host.sv ***
// Host register master model
`timescale 1ns/10ps
`default_nettype none
module dtk_host (
  // Bus
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
  task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_i);
    {addr_o, wdata_o, wr_o, rd_o} <= {a, d, w, !w};
    @(posedge clk_i);
    // Released address and data lines flip and strobes drop so stale values never look valid
    {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'h0};
    #1 q = rdata_i;
  endtask : xfer
endmodule : dtk_host
`default_nettype wire

// *** test/tb_top.sv ***
// Random bench for the display test and key bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys_i = 0, nrst_i = 0, scan_done_i = 0, shutdown_i = 0, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, port_cfg_o, q, scan_hits_i = 0;
  logic [7:0] port_cfg_i = 0;
  logic [5:0] intensity_i = 0, drive_duty_o;
  logic [7:0][7:0] digit_segs_i = '0, drive_segs_o;
  logic drive_enable_o, test_active_o, key_irq_o;
  int err_count = 0, comparisons = 0, mode = 0, deb = 0, prs = 0, h, a, op, e;
  int adr[4] = '{7, 8, 12, 5};
  always #50 clk_sys_i = ~clk_sys_i;
  dtk_host dtk_host_inst (.clk_i(clk_sys_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  dtk_display_test_key_status dtk_display_test_key_status_inst (.*);
  task chk(input logic [63:0] g, w);
    comparisons++;
    if (g !== w) $display("ERROR %0t got %h want %h", $time, g, w);
    err_count += (g !== w);
  endtask : chk
  task tally_and_finish;
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h598AAF4A));
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    dtk_host_inst.xfer(0, 8'h07, 8'h00, q);
    chk(q, 0);
    repeat (600) begin
      h = $urandom;
      a = adr[$urandom_range(3)];
      op = $urandom_range(2);
      if (op < 2) begin
        dtk_host_inst.xfer(op == 0, a[7:0], h[7:0], q);
        e = a == 7 ? mode : a == 8 ? deb : a == 12 ? prs : 0;
        if (op == 1) chk(q, e);
        if (op == 0 && a == 7) mode = h[0];
        if (op == 1 && a == 8) deb = 0;
      end else begin
        @(posedge clk_sys_i);
        {scan_done_i, scan_hits_i} <= {1'b1, h[7:0] & h[15:8]};
        {intensity_i, shutdown_i, port_cfg_i} <= h[30:16];
        digit_segs_i <= {$urandom, h};
        @(posedge clk_sys_i);
        {scan_done_i, scan_hits_i} <= {1'b0, ~(h[7:0] & h[15:8])};
        #1;
        // Only keys seen released last scan may report again
        deb |= h & h >> 8 & ~prs & 255;
        prs = h & h >> 8 & 255;
      end
      chk(test_active_o, mode[0]);
      chk(drive_duty_o, mode ? 6'h1C : intensity_i);
      chk(drive_enable_o, mode || !shutdown_i);
      chk(drive_segs_o, mode ? '1 : digit_segs_i);
      chk(port_cfg_o, port_cfg_i);
      chk(key_irq_o, deb != 0);
    end
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
